// ==== verilog/pclt_pkg.sv ====
// shared constants and types for the power-condition log and timer block
package pclt_pkg;

	// ==================================================================
	// conditions and pages
	localparam int NUM_COND      = 5;
	localparam logic [2:0] COND_IDLE_A = 3'h0;
	localparam logic [2:0] COND_IDLE_B = 3'h1;
	localparam logic [2:0] COND_IDLE_C = 3'h2;
	localparam logic [2:0] COND_STBY_Y = 3'h3;
	localparam logic [2:0] COND_STBY_Z = 3'h4;
	localparam logic [7:0] PAGE_IDLE   = 8'h00;
	localparam logic [7:0] PAGE_STBY   = 8'h01;

	// descriptor placement within a 512 byte page
	localparam logic [8:0] IDLE_A_BASE = 9'h000;
	localparam logic [8:0] IDLE_B_BASE = 9'h040;
	localparam logic [8:0] IDLE_C_BASE = 9'h080;
	localparam logic [8:0] STBY_Y_BASE = 9'h180;
	localparam logic [8:0] STBY_Z_BASE = 9'h1C0;

	// ==================================================================
	// byte positions inside a 64 byte descriptor
	localparam logic [5:0] OFS_FLAGS = 6'h01;
	localparam logic [5:0] OFS_DEF   = 6'h04;
	localparam logic [5:0] OFS_SAV   = 6'h08;
	localparam logic [5:0] OFS_CUR   = 6'h0C;
	localparam logic [5:0] OFS_REC   = 6'h10;
	localparam logic [5:0] OFS_MIN   = 6'h14;
	localparam logic [5:0] OFS_MAX   = 6'h18;
	localparam logic [5:0] OFS_END   = 6'h1C;

	// flag byte bit positions
	localparam int FLG_SUPP = 7;
	localparam int FLG_SAVE = 6;
	localparam int FLG_CHG  = 5;
	localparam int FLG_DEFE = 4;
	localparam int FLG_SAVE_EN = 3;
	localparam int FLG_CURE = 2;

	// ==================================================================
	// register port map (word index)
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_STAT  = 8'h01;
	localparam logic [7:0] REG_SEL   = 8'h02;
	localparam logic [7:0] REG_FLAGS = 8'h03;
	localparam logic [7:0] REG_DEF   = 8'h04;
	localparam logic [7:0] REG_SAV   = 8'h05;
	localparam logic [7:0] REG_CUR   = 8'h06;
	localparam logic [7:0] REG_REC   = 8'h07;
	localparam logic [7:0] REG_MIN   = 8'h08;
	localparam logic [7:0] REG_MAX   = 8'h09;
	localparam logic [7:0] REG_LOG   = 8'h0A;
	localparam logic [31:0] UNMAPPED = 32'h0000_0000;

	// ==================================================================
	// timing
	localparam int CLK_HZ       = 50_000_000;
	localparam int TICK_MS      = 100;
	localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
	localparam logic [31:0] TIMER_INF = 32'hFFFF_FFFF;

	// per-condition settings
	typedef struct packed {
		logic [5:0]  flags;
		logic [31:0] def_t;
		logic [31:0] sav_t;
		logic [31:0] cur_t;
		logic [31:0] rec_t;
		logic [31:0] min_t;
		logic [31:0] max_t;
	} pclt_desc_t;

	// log byte request
	typedef struct packed {
		logic       rd;
		logic [7:0] page;
		logic [8:0] addr;
	} pclt_logreq_t;

endpackage

// ==== verilog/pclt_cond_timer.sv ====
// idle interval counter for one power condition
module pclt_cond_timer
	import pclt_pkg::*;
#(
	parameter int TICK = TICK_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_ce,
	input  wire logic        i_restart,
	input  wire logic        i_enable,
	input  wire logic [31:0] i_setting,
	output logic             o_enter
);

	logic [31:0] pre;
	logic [31:0] ticks;
	logic        tick;
	logic        armed;

	assign tick = (pre == 32'(TICK - 1));

	// zero setting never arms, all-ones never completes
	assign armed = i_enable && (i_setting != 32'h0000_0000)
		&& (i_setting != TIMER_INF);

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pre     <= 32'h0000_0000;
			ticks   <= 32'h0000_0000;
			o_enter <= 1'b0;
		end else if (i_ce) begin
			if (i_restart || !armed) begin
				pre     <= 32'h0000_0000;
				ticks   <= 32'h0000_0000;
				o_enter <= 1'b0;
			end else begin
				pre <= tick ? 32'h0000_0000 : pre + 32'h0000_0001;
				if (tick && ticks != i_setting)
					ticks <= ticks + 32'h0000_0001;
				if (ticks == i_setting)
					o_enter <= 1'b1;
			end
		end
	end

	enter_waits_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_enter) |-> $past(ticks) == i_setting)
		else $error("condition entered before interval elapsed");
	zero_disables_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_ce && i_setting == 32'h0000_0000) |=> !o_enter)
		else $error("zero timer still entered condition");
	inf_never_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_ce && i_setting == TIMER_INF) |=> !o_enter)
		else $error("all-ones timer treated as a count");
	restart_clears_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_ce && i_restart) |=> (ticks == 32'h0 && !o_enter))
		else $error("completion did not restart the interval");

endmodule

// ==== verilog/pclt_desc_byte.sv ====
// byte view of one 64 byte power condition descriptor
module pclt_desc_byte
	import pclt_pkg::*;
(
	input  wire pclt_desc_t i_desc,
	input  wire logic [5:0] i_ofs,
	output logic [7:0]      o_byte
);

	logic [31:0] word;
	logic        in_word;
	logic [1:0]  lane;

	assign lane = i_ofs[1:0];
	assign in_word = (i_ofs >= OFS_DEF) && (i_ofs < OFS_END);

	// timer dwords are little-endian: def, sav, cur, rec, min, max
	assign word = (i_ofs[5:2] == OFS_DEF[5:2]) ? i_desc.def_t :
		(i_ofs[5:2] == OFS_SAV[5:2]) ? i_desc.sav_t :
		(i_ofs[5:2] == OFS_CUR[5:2]) ? i_desc.cur_t :
		(i_ofs[5:2] == OFS_REC[5:2]) ? i_desc.rec_t :
		(i_ofs[5:2] == OFS_MIN[5:2]) ? i_desc.min_t : i_desc.max_t;

	// flag byte carries bits 7..2, bits 1..0 reserved
	assign o_byte = (i_ofs == OFS_FLAGS) ? {i_desc.flags, 2'h0} :
		in_word ? word[8*lane +: 8] : 8'h00;

endmodule

// ==== verilog/pclt_top.sv ====
// power condition log pages and idle/standby entry timers
//
// Design decisions made here: the register offsets and strobed register access.
module pclt_top
	import pclt_pkg::*;
#(
	parameter int TICK = TICK_CYCLES
) (
	input  wire logic        I_CLK,
	input  wire logic        I_NRST,
	input  wire logic        I_CE,
	input  wire logic        I_EPC_SUPPORTED,
	input  wire logic        I_CMD_DONE,
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic [31:0]      O_RDATA,
	output logic [4:0]       O_ENTER,
	output logic             O_LOG_AVAIL
);

	// ==================================================================
	// settings storage
	pclt_desc_t  desc [NUM_COND];
	logic [2:0]  sel;
	logic [7:0]  log_page;
	logic [8:0]  log_addr;
	logic [4:0]  enter;
	logic [7:0]  log_byte;
	logic [31:0] rd_mux;
	logic        sel_ok;
	logic        wr_sel;
	logic        wr_log;
	pclt_desc_t  cur_desc;

	assign sel_ok   = (sel < 3'(NUM_COND));
	assign cur_desc = desc[sel_ok ? sel : COND_IDLE_A];
	assign wr_sel   = I_WR && (I_ADDR == REG_SEL);
	assign wr_log   = I_WR && (I_ADDR == REG_LOG);

	// descriptors: timer fields written by software, no reset on
	// recovery/min/max so they outlive any reset
	genvar g;
	generate
		for (g = 0; g < NUM_COND; g++) begin : g_cond
			logic        hit;
			logic        run;
			logic [5:0]  flags;
			logic [31:0] def_t;
			logic [31:0] sav_t;
			logic [31:0] cur_t;
			logic [31:0] rec_t;
			logic [31:0] min_t;
			logic [31:0] max_t;

			assign hit     = I_WR && sel_ok && (sel == 3'(g));
			assign desc[g] = {flags, def_t, sav_t, cur_t, rec_t, min_t, max_t};
			always_ff @(posedge I_CLK) begin
				if (I_CE && hit && I_ADDR == REG_REC)
					rec_t <= I_WDATA;
				if (I_CE && hit && I_ADDR == REG_MIN)
					min_t <= I_WDATA;
				if (I_CE && hit && I_ADDR == REG_MAX)
					max_t <= I_WDATA;
			end
			always_ff @(posedge I_CLK) begin
				if (!I_NRST) begin
					flags <= 6'h00;
					def_t <= 32'h0000_0000;
					sav_t <= 32'h0000_0000;
					cur_t <= 32'h0000_0000;
				end else if (I_CE && hit) begin
					if (I_ADDR == REG_FLAGS)
						flags <= I_WDATA[7:2];
					if (I_ADDR == REG_DEF)
						def_t <= I_WDATA;
					if (I_ADDR == REG_SAV)
						sav_t <= I_WDATA;
					if (I_ADDR == REG_CUR)
						cur_t <= I_WDATA;
				end
			end

			// current timer enable gates its own counter
			assign run = flags[FLG_SUPP - 2] && flags[FLG_CURE - 2];
			pclt_cond_timer #(
				.TICK(TICK)
			) u_tmr (
				.i_clk    (I_CLK),
				.i_nrst   (I_NRST),
				.i_ce     (I_CE),
				.i_restart(I_CMD_DONE),
				.i_enable (run),
				.i_setting(cur_t),
				.o_enter  (enter[g])
			);
		end
	endgenerate

	// ==================================================================
	// log page byte decode
	logic [8:0]  rel_addr;
	pclt_desc_t  log_desc;
	logic        log_hit;
	logic        in_idle;
	logic        in_stby;
	logic [2:0]  log_cond;

	// idle page: three 64 byte slots from 0, 192-511 reserved
	assign in_idle = (log_page == PAGE_IDLE) && (log_addr < IDLE_C_BASE + 9'h040);
	// standby page: slots at 384 and 448, below is reserved
	assign in_stby = (log_page == PAGE_STBY) && (log_addr >= STBY_Y_BASE);
	assign log_cond = in_idle ? 3'(log_addr[7:6]) :
		(log_addr >= STBY_Z_BASE ? COND_STBY_Z : COND_STBY_Y);
	assign rel_addr = in_idle ? log_addr :
		(log_addr >= STBY_Z_BASE ? log_addr - STBY_Z_BASE : log_addr - STBY_Y_BASE);
	// unsupported feature hides the whole log
	assign log_hit  = I_EPC_SUPPORTED && (in_idle || in_stby);
	assign log_desc = desc[log_cond];

	pclt_desc_byte u_byte (
		.i_desc(log_desc),
		.i_ofs (rel_addr[5:0]),
		.o_byte(log_byte)
	);

	// ==================================================================
	// register port
	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			sel      <= COND_IDLE_A;
			log_page <= PAGE_IDLE;
			log_addr <= 9'h000;
		end else if (I_CE) begin
			if (wr_sel)
				sel <= I_WDATA[2:0];
			if (wr_log) begin
				log_page <= I_WDATA[23:16];
				log_addr <= I_WDATA[8:0];
			end
		end
	end

	assign rd_mux =
		(I_ADDR == REG_CTRL)  ? {31'h0, I_EPC_SUPPORTED} :
		(I_ADDR == REG_STAT)  ? {27'h0, enter} :
		(I_ADDR == REG_SEL)   ? {29'h0, sel} :
		(I_ADDR == REG_FLAGS) ? {24'h0, cur_desc.flags, 2'h0} :
		(I_ADDR == REG_DEF)   ? cur_desc.def_t :
		(I_ADDR == REG_SAV)   ? cur_desc.sav_t :
		(I_ADDR == REG_CUR)   ? cur_desc.cur_t :
		(I_ADDR == REG_REC)   ? cur_desc.rec_t :
		(I_ADDR == REG_MIN)   ? cur_desc.min_t :
		(I_ADDR == REG_MAX)   ? cur_desc.max_t :
		(I_ADDR == REG_LOG)   ? {log_page, 15'h0, log_hit, log_byte & {8{log_hit}}} :
		UNMAPPED;

	always_ff @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_RDATA     <= 32'h0000_0000;
			O_ENTER     <= 5'h00;
			O_LOG_AVAIL <= 1'b0;
		end else if (I_CE) begin
			O_RDATA     <= I_RD ? rd_mux : 32'h0000_0000;
			O_ENTER     <= enter;
			O_LOG_AVAIL <= I_EPC_SUPPORTED;
		end
	end

	// ==================================================================
	// checks
	sequence log_read_s;
		I_RD && I_CE && I_ADDR == REG_LOG;
	endsequence

	// set once the COND_IDLE_A recovery time is written; never reset, like the field
	logic rec_loaded;
	always_ff @(posedge I_CLK) begin
		if (I_CE && I_WR && sel == COND_IDLE_A && I_ADDR == REG_REC)
			rec_loaded <= 1'b1;
	end

	no_log_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(log_read_s ##0 !I_EPC_SUPPORTED) |=> O_RDATA[8:0] == 9'h000)
		else $error("log bytes returned without feature support");
	idle_rsvd_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(log_page == PAGE_IDLE && log_addr >= 9'h0C0) |-> !log_hit)
		else $error("idle page reserved area not reserved");
	stby_rsvd_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(log_page == PAGE_STBY && log_addr < STBY_Y_BASE) |-> !log_hit)
		else $error("standby page leading bytes not reserved");
	flag_low_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(log_hit && rel_addr[5:0] == OFS_FLAGS) |-> log_byte[1:0] == 2'h0)
		else $error("reserved flag bits set");
	enter_gated_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(I_CE && I_CMD_DONE) |=> ##1 O_ENTER == 5'h00)
		else $error("condition held through command completion");
	keep_rec_a: assert property (@(posedge I_CLK)
		(rec_loaded && !I_NRST && !(I_WR && I_ADDR == REG_REC))
		|=> $stable(desc[0].rec_t))
		else $error("recovery time lost over reset");

endmodule

// ==== sim/pclt_host.sv ====
// host model that answers an issued command with a completion pulse
module pclt_host (
	input  wire logic       i_clk,
	input  wire logic       i_issue,
	input  wire logic [3:0] i_lat,
	output logic            o_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt;
	initial begin
		cnt = 5'h00;
		o_done = 1'b0;
	end
	// completion follows the issue after i_lat+1 cycles, prompt or slow
	always @(posedge i_clk) begin
		o_done <= (cnt == 5'h01);
		if (i_issue)
			cnt <= {1'b0, i_lat} + 5'h01;
		else if (cnt != 5'h00)
			cnt <= cnt - 5'h01;
	end
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the power condition log and timer block
module tb
	import pclt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	logic        clk, nrst, epc, wr, rd, issue, avail, done, rd_seen;
	logic [7:0]  addr;
	logic [3:0]  lat;
	logic [31:0] wdata, rdata, seed;
	logic [4:0]  enter;
	logic [63:0] expq[$];
	logic [31:0] fld[5][7];
	logic [31:0] curv[5] = '{32'h3, 32'h0, 32'hFFFF_FFFF, 32'h2, 32'h5};
	int          errors, comparisons, n;

	pclt_top #(.TICK(TK)) dut_u (.I_CLK(clk), .I_NRST(nrst), .I_CE(1'b1),
		.I_EPC_SUPPORTED(epc), .I_CMD_DONE(done), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_ENTER(enter), .O_LOG_AVAIL(avail));
	pclt_host host_u (.i_clk(clk), .i_issue(issue), .i_lat(lat), .o_done(done));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==================================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] eb(int c, int o);
		logic [31:0] w;
		if (o == 1) return fld[c][0][7:0] & 8'hFC;
		if (o < 4 || o > 27) return 8'h00;
		w = fld[c][o / 4];
		return w[8 * (o % 4) +: 8];
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		expq.push_back({m, e});
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic rdl(input logic [7:0] pg, input logic [8:0] a, input logic [7:0] e);
		wreg(REG_LOG, {8'h00, pg, 7'h00, a});
		rreg(REG_LOG, 32'h0000_00FF, {24'h0, e});
	endtask
	task automatic cmd(input logic [3:0] l);
		@(posedge clk);
		lat <= l;
		issue <= 1'b1;
		@(posedge clk);
		issue <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		check(32'(done === 1'b1), 32'h1);
	endtask
	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==================================================================
	// read data observer
	always @(posedge clk) begin
		logic [63:0] q;
		if (rd_seen) begin
			q = expq.pop_front();
			check(rdata & q[63:32], q[31:0]);
		end
		rd_seen <= rd;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("watchdog expired");
		stop_test();
	end

	// ==================================================================
	// main sequence
	initial begin
		nrst = 1'b0;
		epc = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		issue = 1'b0;
		lat = 4'h0;
		addr = 8'h00;
		wdata = 32'h0;
		seed = 32'h42;
		rd_seen = 1'b0;
		errors = 0;
		comparisons = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		rreg(REG_CTRL, 32'hFFFF_FFFF, 32'h1);
		rreg(REG_CUR, 32'hFFFF_FFFF, 32'h0);
		rreg(8'h20, 32'hFFFF_FFFF, 32'h0);
		check({31'h0, avail}, 32'h1);
		$display("test reset done");
		for (int c = 0; c < 5; c++) begin
			fld[c][0] = (rnd() & 32'hF8) | ((c == 3) ? 32'h80 : 32'h84);
			for (int k = 1; k < 7; k++) fld[c][k] = rnd();
			fld[c][3] = curv[c];
			wreg(REG_SEL, c);
			for (int k = 0; k < 7; k++) wreg(REG_FLAGS + 8'(k), fld[c][k]);
			for (int k = 0; k < 7; k++) rreg(REG_FLAGS + 8'(k), (k == 0) ? 32'hFC : 32'hFFFF_FFFF,
				(k == 0) ? (fld[c][0] & 32'hFC) : fld[c][k]);
			for (int o = 0; o < 32; o++)
				rdl((c < 3) ? PAGE_IDLE : PAGE_STBY, ((c < 3) ? 9'(c * 64) : 9'(c * 64 + 192)) + 9'(o),
					eb(c, o));
		end
		rdl(PAGE_IDLE, 9'h0C8, 8'h00);
		rdl(PAGE_STBY, 9'h000, 8'h00);
		rdl(PAGE_STBY, 9'h17F, 8'h00);
		$display("test descriptors done");
		cmd(4'h0);
		repeat (2) @(posedge clk);
		n = 0;
		while (enter[0] !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(32'(n >= 3 * TK), 32'h1);
		check(32'(n <= 3 * TK + 4), 32'h1);
		repeat (30) @(posedge clk);
		check({27'h0, enter}, 32'h11);
		cmd(4'h5);
		repeat (2) @(posedge clk);
		check({27'h0, enter}, 32'h0);
		$display("test timers done");
		@(posedge clk);
		nrst <= 1'b0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		for (int k = 4; k < 7; k++) rreg(REG_FLAGS + 8'(k), 32'hFFFF_FFFF, fld[0][k]);
		rreg(REG_CUR, 32'hFFFF_FFFF, 32'h0);
		rdl(PAGE_IDLE, 9'h010, fld[0][4][7:0]);
		$display("test second reset done");
		@(posedge clk);
		epc <= 1'b0;
		repeat (2) @(posedge clk);
		check({31'h0, avail}, 32'h0);
		rreg(REG_CTRL, 32'hFFFF_FFFF, 32'h0);
		rdl(PAGE_IDLE, 9'h010, 8'h00);
		repeat (4) @(posedge clk);
		$display("test unsupported done");
		stop_test();
	end
endmodule
